// File: dv/nsx_datapath_test.sv
// Self-checking bench for nsx_datapath.
// Drives the ports itself; nsx_sva is bound in.
`timescale 1ns/100ps
module nsx_datapath_test import nsx_pkg::*;;
  logic clk = 0, rst = 1, vld = 0, c = 0, dc = 0, z = 0;
  logic [7:0] acc = 8'h00, dir [3] = '{3{8'hff}};
  nsx_instr_t ins = '0;
  integer errors = 0, checks_done = 0, seed = 32'hc307c45b;
  logic [51:0] q [$];
  wire [7:0] ao, pa, pb, pc;
  wire zo, co, dco, bad;
  nsx_fwrite_t fw;
  wire [51:0] got = {ao, zo, co, dco, fw.we ? 16'(fw) : 16'h0,
    pa, pb, pc, bad};
  nsx_datapath DUT (.i_core_clk(clk), .i_rst(rst), .i_valid(vld),
    .i_instr(ins), .i_carry(c), .i_digit_carry(dc), .o_acc(ao),
    .o_zero(zo), .o_carry(co), .o_digit_carry(dco), .o_fwrite(fw),
    .o_port_a_direction(pa), .o_port_b_direction(pb),
    .o_port_c_direction(pc), .o_bad_operand(bad));
  initial forever #5 clk = ~clk;
  task automatic run(nsx_op_t o, logic d, logic [6:0] a, logic [7:0] l, f);
    logic [7:0] r;
    logic [15:0] w;
    logic b;
    r = o == NSX_OP_SWAP ? {f[3:0], f[7:4]} : acc ^ (o[0] ? f : l);
    w = 16'h0;
    b = o == NSX_OP_DIR && (a < 5 || a > 7);
    if (o == NSX_OP_XORL || o == NSX_OP_XORF) z = r == 8'h00;
    if (o == NSX_OP_DIR && !b) dir[a - 7'h05] = acc;
    else if (d && o != NSX_OP_XORL && !b) w = {1'b1, a, r};
    else if (!b) acc = r;
    @(posedge clk);
    #1;
    vld = 1;
    ins = '{o, d, a, l, f};
    {c, dc} = 2'($random(seed));
    q.push_back({acc, z, c, dc, w, dir[0], dir[1], dir[2], b});
  endtask : run
  always @(posedge clk)
    if (vld)
    begin
      #2;
      checks_done++;
      if (got !== q[0])
      begin
        errors++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, q[0]);
      end
      void'(q.pop_front());
    end
  task automatic end_of_test;
    $display("errors=%0d checks=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  initial
  begin
    #20us;
    errors++;
    end_of_test();
  end
  initial
  begin
    logic [31:0] r;
    repeat (20) @(posedge clk);
    #1 rst = 0;
    run(NSX_OP_XORL, 0, 0, 8'haa, 0);
    run(NSX_OP_XORF, 1, 10, 0, 8'haa);
    run(NSX_OP_SWAP, 0, 3, 0, 8'h3c);
    for (int i = 4; i < 9; i++)
    begin
      run(NSX_OP_XORL, 0, 0, 8'(i), 0);
      run(NSX_OP_DIR, 1, 7'(i), 0, 0);
    end
    repeat (300)
    begin
      r = $random(seed);
      run(nsx_op_t'(r[1:0] + 1), r[2], r[3] ? 7'(r[6:4] + 3) : r[14:8],
        r[23:16], r[31:24]);
    end
    @(posedge clk);
    #1 vld = 0;
    repeat (3) @(posedge clk);
    end_of_test();
  end
endmodule : nsx_datapath_test

// File: dv/nsx_sva.sv
// Port checker for nsx_datapath.
// Bound below to every nsx_datapath.
`timescale 1ns/100ps
module nsx_sva
  import nsx_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  input wire nsx_instr_t i_instr,
  input wire logic i_carry,
  input wire logic [DATA_W-1:0] o_acc,
  input wire logic o_zero,
  input wire logic o_carry,
  input wire nsx_fwrite_t o_fwrite,
  input wire logic [DATA_W-1:0] o_port_b_direction
);
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  wire nsx_op_t op = i_valid ? i_instr.op : NSX_OP_NONE;
  wire [7:0] f = i_instr.file_data;
  wire d = i_instr.dest_file;
  a_swap_file: assert property (op == NSX_OP_SWAP && d |=>
    o_fwrite.data == $past({f[3:0], f[7:4]}) && $stable(o_zero))
    else $error("swap");
  a_dest_acc: assert property (op == NSX_OP_SWAP && !d |=>
    !o_fwrite.we && o_acc == $past({f[3:0], f[7:4]})) else $error("dest");
  a_lit_xor: assert property (op == NSX_OP_XORL |=>
    o_acc == $past(o_acc ^ i_instr.literal)) else $error("xorl");
  a_carry_kept: assert property (op == NSX_OP_XORL |=>
    o_carry == $past(i_carry)) else $error("carry");
  a_file_xor: assert property (op == NSX_OP_XORF && d |=>
    o_fwrite.data == $past(o_acc ^ f) && $stable(o_acc)) else $error("xorf");
  a_dir_flags: assert property (op == NSX_OP_DIR |=>
    $stable(o_zero) && $stable(o_acc)) else $error("dir");
  a_dir_port_b: assert property (op == NSX_OP_DIR &&
    i_instr.addr == DIR_SEL_B |=> o_port_b_direction == $past(o_acc))
    else $error("port b");
  a_zero_flag: assert property (op == NSX_OP_XORL |=>
    o_zero == (o_acc == 8'h00)) else $error("zero");
endmodule : nsx_sva
bind nsx_datapath nsx_sva chk (.*);

// File: src/nsx_alu.sv
// Combinational result and zero-flag logic for the four operations.
// Assumes operands are stable in the cycle the operation is issued.
`timescale 1ns/100ps
module nsx_alu
  import nsx_pkg::*;
(
  input wire nsx_op_t i_op,
  input wire logic [DATA_W-1:0] i_acc,
  input wire logic [DATA_W-1:0] i_literal,
  input wire logic [DATA_W-1:0] i_file_data,
  output logic [DATA_W-1:0] o_result,
  output logic o_is_xor,
  output logic o_zero
);
  always_comb
  begin
    o_is_xor = 1'b0;
    case (i_op)
      NSX_OP_SWAP:
        o_result = {i_file_data[3:0], i_file_data[7:4]};
      NSX_OP_XORL:
      begin
        o_result = i_acc ^ i_literal;
        o_is_xor = 1'b1;
      end
      NSX_OP_XORF:
      begin
        o_result = i_acc ^ i_file_data;
        o_is_xor = 1'b1;
      end
      NSX_OP_DIR:
        o_result = i_acc;
      default:
        o_result = i_acc;
    endcase
    o_zero = (o_result == '0);
  end
endmodule : nsx_alu

// File: src/nsx_datapath.sv
// Execution datapath: accumulator, zero flag, file write-back, direction regs.
// Assumes the decoder presents one instruction per cycle with file data read.
`timescale 1ns/100ps
module nsx_datapath
  import nsx_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  input wire nsx_instr_t i_instr,
  input wire logic i_carry,
  input wire logic i_digit_carry,
  output logic [DATA_W-1:0] o_acc,
  output logic o_zero,
  output logic o_carry,
  output logic o_digit_carry,
  output nsx_fwrite_t o_fwrite,
  output logic [DATA_W-1:0] o_port_a_direction,
  output logic [DATA_W-1:0] o_port_b_direction,
  output logic [DATA_W-1:0] o_port_c_direction,
  output logic o_bad_operand
);
  // Number of direction registers and the operand that selects each one
  localparam int NUM_DIR = 3;
  localparam logic [ADDR_W-1:0] DIR_SEL [NUM_DIR] = '{
    DIR_SEL_A,
    DIR_SEL_B,
    DIR_SEL_C
  };

  // Decoded operation, forced to none when no instruction is presented
  nsx_op_t op;
  logic op_swap;
  logic op_xorl;
  logic op_xorf;
  logic op_dir;
  logic has_dest;
  logic writes_file;
  logic writes_acc;
  logic dir_ok;
  logic [NUM_DIR-1:0] dir_load;

  // Alu outputs
  logic [DATA_W-1:0] result;
  logic is_xor;
  logic res_zero;

  // Next values, one group of state each
  logic [DATA_W-1:0] next_acc;
  logic next_zero;
  logic next_carry;
  logic next_digit_carry;
  nsx_fwrite_t next_fwrite;
  logic next_bad;

  // Decode
  always_comb
  begin
    op = NSX_OP_NONE;
    if (i_valid)
    begin
      op = i_instr.op;
    end
  end

  assign op_swap = (op == NSX_OP_SWAP);
  assign op_xorl = (op == NSX_OP_XORL);
  assign op_xorf = (op == NSX_OP_XORF);
  assign op_dir = (op == NSX_OP_DIR);

  // Only swap and register xor carry a destination bit
  assign has_dest = op_swap || op_xorf;
  assign writes_file = has_dest && i_instr.dest_file;
  assign writes_acc = (has_dest && !i_instr.dest_file) || op_xorl;

  // Operand outside 5..7 selects no register at all
  assign dir_ok = |dir_load;

  nsx_alu u_alu (
    .i_op(op),
    .i_acc(o_acc),
    .i_literal(i_instr.literal),
    .i_file_data(i_instr.file_data),
    .o_result(result),
    .o_is_xor(is_xor),
    .o_zero(res_zero)
  );

  // Accumulator
  always_comb
  begin
    next_acc = o_acc;
    if (writes_acc)
    begin
      next_acc = result;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_acc <= ACC_RESET;
    end
    else
    begin
      o_acc <= next_acc;
    end
  end

  // Zero flag: only the two xor operations touch it
  always_comb
  begin
    next_zero = o_zero;
    if (is_xor)
    begin
      next_zero = res_zero;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_zero <= ZERO_RESET;
    end
    else
    begin
      o_zero <= next_zero;
    end
  end

  // Carry and digit carry are never altered here, only carried through
  always_comb
  begin
    next_carry = i_carry;
    next_digit_carry = i_digit_carry;
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_carry <= 1'b0;
      o_digit_carry <= 1'b0;
    end
    else
    begin
      o_carry <= next_carry;
      o_digit_carry <= next_digit_carry;
    end
  end

  // File write-back, a one-cycle pulse
  always_comb
  begin
    next_fwrite = '0;
    if (writes_file)
    begin
      next_fwrite.we = 1'b1;
      next_fwrite.addr = i_instr.addr;
      next_fwrite.data = result;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_fwrite <= '0;
    end
    else
    begin
      o_fwrite <= next_fwrite;
    end
  end

  // Refused direction load, a one-cycle pulse
  always_comb
  begin
    next_bad = 1'b0;
    if (op_dir && !dir_ok)
    begin
      next_bad = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_bad_operand <= 1'b0;
    end
    else
    begin
      o_bad_operand <= next_bad;
    end
  end

  // Direction registers, one per port
  generate
    for (genvar k = 0; k < NUM_DIR; k++)
    begin : g_dir
      logic load;
      logic [DATA_W-1:0] next_dir;
      logic [DATA_W-1:0] dir_q;

      assign load = op_dir && (i_instr.addr == DIR_SEL[k]);
      assign dir_load[k] = load;

      always_comb
      begin
        next_dir = dir_q;
        if (load)
        begin
          next_dir = result;
        end
      end

      always_ff @(posedge i_core_clk or posedge i_rst)
      begin
        if (i_rst)
        begin
          dir_q <= DIR_RESET;
        end
        else
        begin
          dir_q <= next_dir;
        end
      end
    end
  endgenerate

  // Outputs straight from the direction flip-flops
  assign o_port_a_direction = g_dir[0].dir_q;
  assign o_port_b_direction = g_dir[1].dir_q;
  assign o_port_c_direction = g_dir[2].dir_q;
endmodule : nsx_datapath

// File: src/nsx_pkg.sv
// Package for the nibble-swap / xor / direction-load datapath.
// Assumes one core clock and an instruction decoder outside this block.
package nsx_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam logic [ADDR_W-1:0] DIR_SEL_A = 7'h05;
  localparam logic [ADDR_W-1:0] DIR_SEL_B = 7'h06;
  localparam logic [ADDR_W-1:0] DIR_SEL_C = 7'h07;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DIR_RESET = 8'hff;
  localparam logic ZERO_RESET = 1'h0;

  typedef enum logic [3:0] {
    NSX_OP_NONE = 4'h0,
    NSX_OP_SWAP = 4'h1,
    NSX_OP_XORL = 4'h2,
    NSX_OP_XORF = 4'h3,
    NSX_OP_DIR  = 4'h4
  } nsx_op_t;

  typedef struct packed {
    nsx_op_t op;
    logic dest_file;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] literal;
    logic [DATA_W-1:0] file_data;
  } nsx_instr_t;

  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } nsx_fwrite_t;
endpackage : nsx_pkg
